// ==== rtl/seepw_bitcap.sv ====
`timescale 1ns/100ps

// Link-side sampler: each rising link clock captures the data line
// and flips a toggle that announces the new bit to the core clock.
module seepw_bitcap (
  input wire logic scl_in,
  input wire logic rst_in,
  input wire logic sda_in,
  output logic bit_out,
  output logic tgl_out
);

  // ==========================================================
  // Capture.
  // The bit stays put for a whole link period, far longer than the
  // core needs to see the toggle, so bit and toggle need no handshake.
  always_ff @(posedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      bit_out <= 1'b1;
      tgl_out <= 1'b0;
    end else begin
      bit_out <= sda_in;
      tgl_out <= ~tgl_out;
    end
  end

endmodule

// ==== rtl/seepw_fifo.sv ====
`timescale 1ns/100ps

module seepw_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_push;
  wire do_pop;

  // ==========================================================
  // Handshake terms; full and empty come from the true occupancy.
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign do_push = in_valid_in & in_ready_out;
  assign do_pop = out_valid_out & out_ready_in;
  assign out_data_out = mem[rd_ptr];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ==========================================================
  // Pointers and occupancy.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= wrap_inc(wr_ptr);
      if (do_pop) rd_ptr <= wrap_inc(rd_ptr);
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Storage carries no reset; only written slots are ever read.
  always_ff @(posedge mclk_in) begin
    if (do_push) mem[wr_ptr] <= in_data_in;
  end

endmodule

// ==== rtl/seepw_pkg.sv ====
package seepw_pkg;

  // ==========================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TWC_MAX_NS = 5000000;
  localparam int TWC_TYP_NS = 3000000;
  // Longest time, so the division rounds down.
  localparam int TWC_CYCLES = TWC_MAX_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Geometry and protocol constants.
  localparam int PAGE_BYTES_DEF = 128;
  localparam int ADDR_BYTES_DEF = 2;
  localparam int MEM_AW = 10;
  localparam int MEM_BYTES = 1024;
  localparam int FIFO_DEPTH = 4;
  // Arbitrary bus select value; replace per board.
  localparam logic [6:0] DEV_SEL_DEF = 7'h2A;
  localparam logic WRITE_BIT = 1'b0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [2:0] SYNC_ZERO = 3'h0;

  // ==========================================================
  // Types.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CTRL = 5'h02,
    ST_ADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_SKIP = 5'h10
  } seepw_frame_t;

  typedef enum logic [2:0] {
    WC_IDLE = 3'h1,
    WC_PROG = 3'h2,
    WC_HOLD = 3'h4
  } seepw_wc_t;

  typedef struct packed {
    logic is_data;
    logic [7:0] data;
  } seepw_byte_t;

endpackage

// ==== rtl/seepw_top.sv ====
`timescale 1ns/100ps

// Notes on behaviour
// - Selected and not busy: acknowledge every received byte by pulling data low.
// - While the write cycle runs, every access attempt is ignored.
// - Stop ending a write command starts the self-timed write cycle.
// - Busy: leave control byte unacknowledged; acknowledge again once done.
// - One write accepts one byte up to a full page into the buffer.
// - Word address loads row pointer and column pointer.
// - Each received data byte advances the column pointer by one.
// - Row stays fixed; column wraps within page, later bytes overwrite.
// - Pages start at whole multiples of the page size.
// - Page write: control, address, data bytes without Stop, all buffered.
// - At Stop, all buffered bytes are programmed in one write cycle.
// - Word address is one or two bytes, per build parameter.
// - Write cycle finishes within 5 ms worst case, 3 ms typical; the core always takes the full worst-case time.
module seepw_top
#(
  parameter int PAGE_BYTES = seepw_pkg::PAGE_BYTES_DEF,
  parameter int ADDR_BYTES = seepw_pkg::ADDR_BYTES_DEF,
  parameter int WC_CYCLES = seepw_pkg::TWC_CYCLES,
  parameter logic [6:0] DEV_SEL = seepw_pkg::DEV_SEL_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic busy_out,
  input wire logic [seepw_pkg::MEM_AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  import seepw_pkg::*;

  // Page geometry follows the build parameter.
  localparam int PW = $clog2(PAGE_BYTES);
  localparam logic [PW-1:0] COL_LAST = PW'(PAGE_BYTES - 1);
  localparam logic [1:0] NAB_INIT = 2'(ADDR_BYTES);

  // ==========================================================
  // Declarations.
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] filt;
  logic [2:0] filt_prev;
  logic [2:0] next_filt;
  wire link_bit;
  wire link_tgl;
  wire start_det;
  wire stop_det;
  wire scl_fall;
  wire bit_evt;
  wire [7:0] byte_now;
  wire ctrl_ok;
  wire busy_now;

  seepw_frame_t state;
  seepw_frame_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [1:0] nab;
  logic [1:0] next_nab;
  logic ack_pend;
  logic next_ack;
  logic stop_pend;
  logic next_stop;
  logic selw;
  logic next_selw;
  logic next_oe;
  logic push;

  seepw_byte_t push_byte;
  seepw_byte_t pop_byte;
  logic fifo_in_ready;
  logic fifo_out_valid;
  wire fifo_out_ready;
  wire take;

  seepw_wc_t wc;
  seepw_wc_t next_wc;
  logic [MEM_AW-1:0] ptr;
  logic [MEM_AW-1:0] next_ptr;
  logic [PAGE_BYTES-1:0] dirty;
  logic [PAGE_BYTES-1:0] next_dirty;
  logic [PW-1:0] idx;
  logic [PW-1:0] next_idx;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic stop_clr;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [MEM_BYTES];

  // A synchronised bit only changes once its last two stages agree.
  function automatic logic [2:0] settle(input logic [2:0] cur,
                                        input logic [2:0] s2,
                                        input logic [2:0] s3);
    logic [2:0] agree;
    agree = ~(s2 ^ s3);
    settle = (s2 & agree) | (cur & ~agree);
  endfunction

  // ==========================================================
  // Link domain sampler.
  seepw_bitcap u_bitcap (
    .scl_in(scl_in),
    .rst_in(rst_in),
    .sda_in(sda_in),
    .bit_out(link_bit),
    .tgl_out(link_tgl)
  );

  // ==========================================================
  // Pin and toggle synchronisers: bit 0 clock line, 1 data line,
  // 2 link toggle. Only sync2 reads sync1.
  assign next_filt = settle(filt, sync2, sync3);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 3'h3;
      sync2 <= 3'h3;
      sync3 <= 3'h3;
      filt <= 3'h3;
      filt_prev <= 3'h3;
    end else begin
      sync1 <= {link_tgl, sda_in, scl_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_prev <= filt;
    end
  end

  // Bus events seen on settled pin levels.
  assign start_det = filt[0] & filt_prev[0] & filt_prev[1] & ~filt[1];
  assign stop_det = filt[0] & filt_prev[0] & ~filt_prev[1] & filt[1];
  assign scl_fall = filt_prev[0] & ~filt[0];
  assign bit_evt = filt[2] ^ filt_prev[2];

  // ==========================================================
  // Byte decode; link_bit is steady whenever its toggle is seen.
  assign byte_now = {shreg[6:0], link_bit};
  // A pending Stop counts as busy, so an early poll is refused too.
  assign busy_now = (wc != WC_IDLE) | stop_pend;
  assign ctrl_ok = (byte_now[7:1] == DEV_SEL) &
                   (byte_now[0] == WRITE_BIT) & ~busy_now;
  assign push_byte.is_data = (state == ST_DATA);
  assign push_byte.data = byte_now;

  // Framing: nine link clocks per byte, the ninth being the acknowledge.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_nab = nab;
    next_ack = ack_pend;
    next_stop = stop_pend;
    next_selw = selw;
    next_oe = sda_oe_out;
    push = 1'b0;
    if (stop_clr) next_stop = 1'b0;
    if (scl_fall && cnt == ACK_BIT && ack_pend) begin
      next_oe = 1'b0;
      next_ack = 1'b0;
    end else if (scl_fall && cnt == CNT_ZERO) begin
      next_oe = 1'b1;
    end
    if (start_det) begin
      next_state = ST_CTRL;
      next_cnt = CNT_ZERO;
      next_selw = 1'b0;
      next_ack = 1'b0;
      next_oe = 1'b1;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_cnt = CNT_ZERO;
      next_ack = 1'b0;
      next_oe = 1'b1;
      next_selw = 1'b0;
      if (selw) next_stop = 1'b1;
    end else if (bit_evt) begin
      if (cnt == ACK_BIT) begin
        next_cnt = CNT_ZERO;
      end else begin
        next_shreg = byte_now;
        next_cnt = cnt + 4'h1;
      end
      if (cnt == LAST_BIT) begin
        unique case (state)
          ST_CTRL: begin
            if (ctrl_ok) begin
              next_ack = 1'b1;
              next_selw = 1'b1;
              next_nab = NAB_INIT;
              next_state = ST_ADDR;
            end else begin
              next_state = ST_SKIP;
            end
          end
          ST_ADDR, ST_DATA: begin
            if (fifo_in_ready) begin
              push = 1'b1;
              next_ack = 1'b1;
              if (state == ST_ADDR) next_nab = nab - 2'h1;
              if (state == ST_ADDR && nab == 2'h1) next_state = ST_DATA;
            end else begin
              next_state = ST_SKIP;
            end
          end
          ST_IDLE, ST_SKIP: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      shreg <= 8'h00;
      nab <= 2'h0;
      ack_pend <= 1'b0;
      stop_pend <= 1'b0;
      selw <= 1'b0;
      sda_oe_out <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      nab <= next_nab;
      ack_pend <= next_ack;
      stop_pend <= next_stop;
      selw <= next_selw;
      sda_oe_out <= next_oe;
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // Byte FIFO. When full, the link byte is not acknowledged.
  seepw_fifo #(
    .W($bits(seepw_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_byte),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(pop_byte)
  );

  // Draining stalls during the write cycle.
  assign fifo_out_ready = (wc == WC_IDLE);
  assign take = fifo_out_valid & fifo_out_ready;

  // ==========================================================
  // Page buffer pointers and the timed write cycle.
  always_comb begin
    next_wc = wc;
    next_ptr = ptr;
    next_dirty = dirty;
    next_idx = idx;
    next_timer = timer;
    stop_clr = 1'b0;
    if (take && !pop_byte.is_data) begin
      next_ptr = {ptr[MEM_AW-9:0], pop_byte.data};
      next_dirty = '0; // Bytes of a write cut by a Start are dropped once the next address byte arrives.
    end else if (take) begin
      next_dirty[ptr[PW-1:0]] = 1'b1;
      // Row bits stay; column wraps inside the page.
      next_ptr = {ptr[MEM_AW-1:PW], ptr[PW-1:0] + 1'b1};
    end
    unique case (wc)
      WC_IDLE: begin
        if (stop_pend && !fifo_out_valid) begin
          stop_clr = 1'b1;
          next_idx = '0;
          next_timer = 32'h0;
          if (|dirty) next_wc = WC_PROG;
        end
      end
      WC_PROG: begin
        next_idx = idx + 1'b1;
        next_timer = timer + 32'h1;
        if (idx == COL_LAST) next_wc = WC_HOLD;
      end
      WC_HOLD: begin
        next_timer = timer + 32'h1;
        if (timer >= 32'(WC_CYCLES - 1)) begin
          next_wc = WC_IDLE;
          next_dirty = '0;
        end
      end
      default: next_wc = WC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wc <= WC_IDLE;
      ptr <= '0;
      dirty <= '0;
      idx <= '0;
      timer <= 32'h0;
      busy_out <= 1'b0;
    end else begin
      wc <= next_wc;
      ptr <= next_ptr;
      dirty <= next_dirty;
      idx <= next_idx;
      timer <= next_timer;
      busy_out <= (next_wc != WC_IDLE);
    end
  end

  // Arrays carry no reset. Pages sit on multiples of the page size,
  // so the cell address is row bits over the buffer index.
  always_ff @(posedge mclk_in) begin
    if (take && pop_byte.is_data) pbuf[ptr[PW-1:0]] <= pop_byte.data;
    if (wc == WC_PROG && dirty[idx]) begin
      mem[{ptr[MEM_AW-1:PW], idx}] <= pbuf[idx];
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// ==== sim/seepw_master_model.sv ====
`timescale 1ns/100ps

// ==================================================
// Link master; a 30 ns timebase paces scl, which stands high
// outside frames. Each scl level lasts four ticks so the core's
// synchroniser sees it well.
module seepw_master_model (
  output logic scl_out,
  output logic sda_rel_out,
  input wire logic sda_in
);
  logic lclk = 1'b0;
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  task tk(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask
  // Data changes only mid low phase; the level is read mid high.
  task clk(input logic b, output logic s);
    tk(2);
    sda_rel_out = b;
    tk(2);
    scl_out = 1'b1;
    tk(2);
    s = sda_in;
    tk(2);
    scl_out = 1'b0;
  endtask
  task start();
    tk(2);
    sda_rel_out = 1'b1;
    tk(2);
    scl_out = 1'b1;
    tk(4);
    sda_rel_out = 1'b0;
    tk(4);
    scl_out = 1'b0;
  endtask
  // Eight bits MSB first, then a released ninth clock for the answer.
  task put(input logic [7:0] d, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) clk(d[i], s);
    clk(1'b1, a);
  endtask
  task stop();
    tk(2);
    sda_rel_out = 1'b0;
    tk(2);
    scl_out = 1'b1;
    tk(4);
    sda_rel_out = 1'b1;
    tk(4);
  endtask
endmodule

// ==== sim/seepw_top_asserts.sv ====
`timescale 1ns/100ps

// ==================================================
// Port checker for the write path.
module seepw_top_asserts #(
  parameter int WC_CYCLES = 625000
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic busy_out
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bitn;
  logic [4:0] stop_age;
  int bcnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Raw pin tracking; the core's synchroniser lags by a few cycles,
  // which is why the stop bound is loose.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitn <= 4'h0;
      stop_age <= 5'h1F;
      bcnt <= 0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      bcnt <= busy_out ? bcnt + 1 : 0;
      if (scl_in && sda_q && !sda_in) bitn <= 4'h0;
      else if (scl_in && !scl_q) bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
      if (scl_in && !sda_q && sda_in) stop_age <= 5'h00;
      else if (stop_age != 5'h1F) stop_age <= stop_age + 5'h01;
    end
  end

  // Acknowledge only in the ninth clock, begun while the clock is low.
  chk_reset_idle: assert property (
    $fell(rst_in) |-> sda_oe_out && !busy_out) else $error("not idle");
  chk_ack_drive_low: assert property (
    !sda_oe_out |-> !sda_out) else $error("ack not low");
  chk_ack_on_ninth: assert property (
    !sda_oe_out && scl_in && scl_q |-> bitn == 4'h9)
    else $error("ack outside ninth clock");
  chk_ack_scl_low: assert property (
    $fell(sda_oe_out) |-> !scl_in) else $error("ack began at high");
  chk_ack_stands: assert property (
    $rose(scl_in) && !sda_oe_out |-> !sda_oe_out [*8])
    else $error("ack dropped early");
  // A write cycle shuts out every access and is started by a stop.
  chk_busy_no_ack: assert property (
    busy_out |-> sda_oe_out) else $error("ack while busy");
  chk_busy_after_stop: assert property (
    $rose(busy_out) |-> stop_age <= 5'h10) else $error("busy w/o stop");
  chk_busy_length: assert property (
    $fell(busy_out) |-> bcnt >= WC_CYCLES - 1 && bcnt <= WC_CYCLES + 1)
    else $error("write cycle length wrong");
  cov_ack: cover property ($fell(sda_oe_out));
  cov_busy_rise: cover property ($rose(busy_out));
  cov_busy_fall: cover property ($fell(busy_out));
endmodule

bind seepw_top seepw_top_asserts #(.WC_CYCLES(WC_CYCLES))
  seepw_top_asserts_inst (
  .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .busy_out(busy_out)
);

// ==== sim/seepw_top_tb_top.sv ====
`timescale 1ns/100ps

module seepw_top_tb_top;
  import seepw_pkg::*;
  // ==================================================
  // Short page and cycle keep the run brief.
  localparam int PB = 8;
  localparam int WC = 2000;
  localparam logic [7:0] CW = {DEV_SEL_DEF, WRITE_BIT};
  logic mclk_in = 1'b0;
  logic rst_in;
  logic [MEM_AW-1:0] rd_addr_in = '0;
  logic sda_out;
  logic sda_oe_out;
  logic busy_out;
  logic [7:0] rd_data_out;
  logic scl_w;
  logic m_sda;
  wire sda_w;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;

  always #4 mclk_in = ~mclk_in;
  // Pulled-up wire: low when either party pulls it.
  assign sda_w = m_sda & (sda_oe_out | sda_out);
  seepw_master_model seepw_master_model_inst (
    .scl_out(scl_w), .sda_rel_out(m_sda), .sda_in(sda_w));
  seepw_top #(.PAGE_BYTES(PB), .WC_CYCLES(WC)) seepw_top_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
    .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out));

  // ==================================================
  // Compare and bus helpers.
  task chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task chk_byte(input string what, input logic [7:0] exp,
                input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task send(input logic [7:0] b, input logic exp);
    logic a;
    seepw_master_model_inst.put(b, a);
    chk_bit("ack level", exp, a);
  endtask
  task rd(input logic [MEM_AW-1:0] ad, input logic [7:0] exp);
    @(posedge mclk_in);
    #1 rd_addr_in = ad;
    repeat (2) @(posedge mclk_in);
    #1 chk_byte("memory byte", exp, rd_data_out);
  endtask
  // Start plus write control again until the device answers.
  task poll(output int n);
    logic a;
    n = 0;
    a = 1'b1;
    while (a === 1'b1 && n < 40) begin
      seepw_master_model_inst.start();
      seepw_master_model_inst.put(CW, a);
      n++;
    end
    seepw_master_model_inst.stop();
    chk_bit("poll answer", 1'b0, a);
  endtask

  // ==================================================
  // Scenarios.
  // Foreign select and read are refused; address-only starts no cycle.
  task t_select();
    seepw_master_model_inst.start();
    send({DEV_SEL_DEF ^ 7'h01, WRITE_BIT}, 1'b1);
    seepw_master_model_inst.stop();
    seepw_master_model_inst.start();
    send({DEV_SEL_DEF, 1'b1}, 1'b1);
    seepw_master_model_inst.start();
    send(CW, 1'b0);
    send(8'h00, 1'b0);
    send(8'h40, 1'b0);
    seepw_master_model_inst.stop();
    repeat (20) @(posedge mclk_in);
    chk_bit("busy without data", 1'b0, busy_out);
    $display("t_select done");
  endtask
  // Ten bytes from column 5 wrap inside the page and overwrite.
  task t_page_wrap();
    logic [7:0] exp [PB];
    int n;
    seepw_master_model_inst.start();
    send(CW, 1'b0);
    send(8'hFC, 1'b0);
    send(8'h15, 1'b0);
    for (int j = 0; j < 10; j++) begin
      send(8'hA0 + j[7:0], 1'b0);
      exp[(5 + j) % PB] = 8'hA0 + j[7:0];
    end
    seepw_master_model_inst.stop();
    repeat (20) @(posedge mclk_in);
    chk_bit("busy after stop", 1'b1, busy_out);
    poll(n);
    chk_bit("polls refused", 1'b1, n > 1);
    for (int j = 0; j < PB; j++) begin
      rd(10'h010 + j[9:0], exp[j]);
    end
    $display("t_page_wrap done");
  endtask
  // A write attempt during the cycle is ignored whole.
  task t_busy_refuse();
    int n;
    seepw_master_model_inst.start();
    send(CW, 1'b0);
    send(8'h00, 1'b0);
    send(8'h30, 1'b0);
    send(8'h55, 1'b0);
    seepw_master_model_inst.stop();
    seepw_master_model_inst.start();
    send(CW, 1'b1);
    send(8'h00, 1'b1);
    send(8'h30, 1'b1);
    send(8'hAA, 1'b1);
    seepw_master_model_inst.stop();
    chk_bit("busy kept", 1'b1, busy_out);
    poll(n);
    rd(10'h030, 8'h55);
    $display("t_busy_refuse done");
  endtask
  // One byte, then a fixed worst-case wait; the first poll after it must be answered.
  task t_fixed_wait();
    int n;
    seepw_master_model_inst.start();
    send(CW, 1'b0);
    send(8'h00, 1'b0);
    send(8'h2B, 1'b0);
    send(8'h3C, 1'b0);
    seepw_master_model_inst.stop();
    repeat (WC + 40) @(posedge mclk_in);
    #1 chk_bit("busy after wait", 1'b0, busy_out);
    poll(n);
    chk_bit("first poll answered", 1'b1, n == 1);
    rd(10'h02B, 8'h3C);
    $display("t_fixed_wait done");
  endtask

  task test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The run needs about 15000 cycles; the ceiling leaves margin.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    rst_in = 1'b1;
    repeat (6) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    repeat (8) @(posedge mclk_in);
    t_select();
    t_page_wrap();
    t_busy_refuse();
    t_fixed_wait();
    test_done();
  end
endmodule
